// ===== t16oc_regs.vh
// How it works
// (RQ1) each channel compares full count against compare_value
// (RQ2) match flag sets one timer tick later
// (RQ3) enabled flag requests irq; cleared on service
// (RQ4) writing one clears flag, zero keeps it
// (RQ5) output derived from match, mode, action, extremes
// (RQ6) channel A value can serve as ceiling
// (RQ7) buffered in twelve pwm modes, else direct
// (RQ8) buffer loads active only at ceiling/floor
// (RQ9) cpu reaches buffer or active per mode
// (RQ10) only cpu writes change value; high reads direct
// (RQ11) high byte held, low write loads sixteen bits
// (RQ12) force updates output only, non-pwm modes
// (RQ13) count write blocks matches next timer tick
// (RQ14) count written at ceiling: ceiling match ignored
// (RQ15) software avoids writing floor while counting down
// (RQ16) output register keeps value across mode changes
// (RQ17) action setting acts from next match, unbuffered
// (RQ18) reset clears output register to zero
// (RQ19) nonzero action overrides port data; direction kept
// (RQ20) action setting never touches input capture
// (RQ21) action zero leaves output unchanged on match
// (RQ22) mode zero is normal, non-pwm
// (RQ23) modes 4 and 12 clear on match
// (RQ24) fast pwm: match clears/sets, floor sets/clears
// (RQ25) non-pwm actions 1,2,3: toggle, clear, set
// (RQ26) force strobe is one cycle, reads zero
// (RQ27) channels A and B are identical instances
`ifndef T16OC_REGS_VH
`define T16OC_REGS_VH

// register offsets on the 8-bit wishbone bus
`define T16OC_ADR_MODE     4'h0
`define T16OC_ADR_CTRL_A   4'h1
`define T16OC_ADR_CTRL_B   4'h2
`define T16OC_ADR_FLAGS    4'h3
`define T16OC_ADR_VAL_A_LO 4'h4
`define T16OC_ADR_VAL_A_HI 4'h5
`define T16OC_ADR_VAL_B_LO 4'h6
`define T16OC_ADR_VAL_B_HI 4'h7

// fields of a channel control register
`define T16OC_ACT_LSB      0
`define T16OC_ACT_MSB      1
`define T16OC_IRQEN_BIT    2
`define T16OC_FORCE_BIT    3

// action encodings
`define T16OC_ACT_NONE     2'h0
`define T16OC_ACT_TOGGLE   2'h1
`define T16OC_ACT_CLEAR    2'h2
`define T16OC_ACT_SET      2'h3

// waveform_select values with special meaning
`define T16OC_WS_NORMAL    4'h0
`define T16OC_WS_CTC_A     4'h4
`define T16OC_WS_CTC_CAP   4'hc
`define T16OC_WS_RESERVED  4'hd
`define T16OC_WS_FAST_8    4'h5
`define T16OC_WS_FAST_9    4'h6
`define T16OC_WS_FAST_10   4'h7
`define T16OC_WS_FAST_CAP  4'he
`define T16OC_WS_FAST_A    4'hf
`define T16OC_WS_PFC_CAP   4'h8
`define T16OC_WS_PFC_A     4'h9
`define T16OC_WS_PC_A      4'hb

// reset values
`define T16OC_RST_MODE     4'h0
`define T16OC_RST_VALUE    16'h0000

`endif

// ===== t16oc.v
// Our own choices: the register addresses and the Wishbone slave port.
`include "t16oc_regs.vh"

module t16oc (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [0:0]  wb_sel_i,
    input  wire [7:0]  wb_dat_i,
    output reg  [7:0]  wb_dat_o,
    output reg         wb_ack_o,
    input  wire [15:0] timer_count_i,
    input  wire        timer_tick_i,
    input  wire        timer_count_write_i,
    input  wire        count_ceiling_i,
    input  wire        count_floor_i,
    input  wire        count_down_i,
    input  wire [1:0]  irq_ack_i,
    input  wire [1:0]  port_data_i,
    input  wire [1:0]  pin_direction_bit_i,
    output reg  [1:0]  compare_irq_o,
    output reg  [1:0]  waveform_pin_o,
    output reg  [1:0]  waveform_oe_o,
    output reg  [15:0] ceiling_value_o,
    output reg  [3:0]  waveform_select_o
);

    ////////////////////////////////////////////////////////////////////////////
    // mode decoding

    // true in the twelve pwm modes; normal, both ctc and reserved are not
    function is_pwm;
        input [3:0] ws;
        begin
            is_pwm = !(ws == `T16OC_WS_NORMAL || ws == `T16OC_WS_CTC_A ||
                       ws == `T16OC_WS_CTC_CAP || ws == `T16OC_WS_RESERVED); // RQ7 RQ22 RQ23
        end
    endfunction

    // single-slope modes
    function is_fast;
        input [3:0] ws;
        begin
            is_fast = (ws == `T16OC_WS_FAST_8) || (ws == `T16OC_WS_FAST_9) ||
                      (ws == `T16OC_WS_FAST_10) || (ws == `T16OC_WS_FAST_CAP) ||
                      (ws == `T16OC_WS_FAST_A);
        end
    endfunction

    // modes whose buffer moves to active at the floor instead of the ceiling
    function load_at_floor;
        input [3:0] ws;
        begin
            load_at_floor = (ws == `T16OC_WS_PFC_CAP) || (ws == `T16OC_WS_PFC_A);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack for one cycle, unmapped reads zero

    reg  [3:0]  waveform_select;
    reg  [7:0]  high_byte_holding;
    reg         match_block;
    wire        bus_req  = wb_cyc_i & wb_stb_i;
    wire        bus_wr   = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire        pwm_mode = is_pwm(waveform_select);
    wire        fast     = is_fast(waveform_select);
    wire        floor_ld = load_at_floor(waveform_select);

    wire [15:0] active_val [0:1];
    wire [15:0] buffer_val [0:1];
    wire [7:0]  ctrl_rd    [0:1];
    wire [1:0]  flag_rd;
    wire [1:0]  pin_next;

    // read data is latched with ack, so it is stable while ack is high
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            case (wb_adr_i)
                `T16OC_ADR_MODE:     wb_dat_o <= {4'h0, waveform_select};
                `T16OC_ADR_CTRL_A:   wb_dat_o <= ctrl_rd[0];
                `T16OC_ADR_CTRL_B:   wb_dat_o <= ctrl_rd[1];
                `T16OC_ADR_FLAGS:    wb_dat_o <= {6'h00, flag_rd};
                // value reads never pass through the holding byte
                `T16OC_ADR_VAL_A_LO: wb_dat_o <= pwm_mode ? buffer_val[0][7:0]  : active_val[0][7:0];
                `T16OC_ADR_VAL_A_HI: wb_dat_o <= pwm_mode ? buffer_val[0][15:8] : active_val[0][15:8]; // RQ10 RQ9
                `T16OC_ADR_VAL_B_LO: wb_dat_o <= pwm_mode ? buffer_val[1][7:0]  : active_val[1][7:0];
                `T16OC_ADR_VAL_B_HI: wb_dat_o <= pwm_mode ? buffer_val[1][15:8] : active_val[1][15:8]; // RQ10 RQ9
                default:             wb_dat_o <= 8'h00;
            endcase
        end
    end

    // mode register and shared high-byte holding register
    always @(posedge clk_i) begin
        if (rst_i) begin
            waveform_select   <= `T16OC_RST_MODE;
            high_byte_holding <= 8'h00;
        end else if (bus_wr) begin
            if (wb_adr_i == `T16OC_ADR_MODE)
                waveform_select <= wb_dat_i[3:0]; // RQ16
            if (wb_adr_i == `T16OC_ADR_VAL_A_HI || wb_adr_i == `T16OC_ADR_VAL_B_HI)
                high_byte_holding <= wb_dat_i; // RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // match blocking: a count write hides matches until the next tick has passed

    // held across a stopped timer, since no tick clears it
    always @(posedge clk_i) begin
        if (rst_i)
            match_block <= 1'b0;
        else if (timer_tick_i)
            match_block <= 1'b0; // RQ13
        else if (timer_count_write_i)
            match_block <= 1'b1; // RQ13 RQ14
    end

    // the write cycle itself is blocked too, so a tick beside the write cannot match
    wire        blocked  = match_block | timer_count_write_i; // RQ13

    ////////////////////////////////////////////////////////////////////////////
    // compare channels, two identical copies

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_chan // RQ27
            reg  [15:0] active;
            reg  [15:0] buffer;
            reg  [1:0]  action;
            reg         irq_en;
            reg         flag;
            reg         match_seen;
            reg         wave;
            reg         next_wave;
            wire [3:0]  lo_adr  = (c == 0) ? `T16OC_ADR_VAL_A_LO : `T16OC_ADR_VAL_B_LO;
            wire [3:0]  ctl_adr = (c == 0) ? `T16OC_ADR_CTRL_A : `T16OC_ADR_CTRL_B;
            wire        lo_wr   = bus_wr & (wb_adr_i == lo_adr);
            wire        ctl_wr  = bus_wr & (wb_adr_i == ctl_adr);
            // a force written together with a new action applies that new action
            wire [1:0]  eff_act = ctl_wr ? wb_dat_i[`T16OC_ACT_MSB:`T16OC_ACT_LSB] : action;
            wire        force_s = ctl_wr & wb_dat_i[`T16OC_FORCE_BIT] & ~pwm_mode;
            wire        match   = (timer_count_i == active); // RQ1
            wire        hit     = timer_tick_i & match & ~blocked; // RQ13
            wire        flag_clr = (bus_wr & (wb_adr_i == `T16OC_ADR_FLAGS) & wb_dat_i[c])
                                   | irq_ack_i[c];

            assign active_val[c] = active;
            assign buffer_val[c] = buffer;
            // strobe bit is not stored, so it reads back zero
            assign ctrl_rd[c]    = {5'h00, irq_en, action}; // RQ26
            assign flag_rd[c]    = flag;
            // the port data shows unless an action is selected
            assign pin_next[c]   = (action != `T16OC_ACT_NONE) ? wave : port_data_i[c]; // RQ19

            // control bits take effect at once, unbuffered
            always @(posedge clk_i) begin
                if (rst_i) begin
                    action <= `T16OC_ACT_NONE;
                    irq_en <= 1'b0;
                end else if (ctl_wr) begin
                    action <= wb_dat_i[`T16OC_ACT_MSB:`T16OC_ACT_LSB]; // RQ17
                    irq_en <= wb_dat_i[`T16OC_IRQEN_BIT];
                end
            end

            // value registers: cpu writes land in the buffer in pwm modes,
            // directly in the active copy otherwise; hardware only moves
            // the buffer over at the chosen extreme
            always @(posedge clk_i) begin
                if (rst_i) begin
                    active <= `T16OC_RST_VALUE;
                    buffer <= `T16OC_RST_VALUE;
                end else begin
                    if (lo_wr) begin
                        buffer <= {high_byte_holding, wb_dat_i}; // RQ11 RQ10
                        if (!pwm_mode)
                            active <= {high_byte_holding, wb_dat_i}; // RQ9 RQ7
                    end
                    if (pwm_mode && timer_tick_i &&
                        (floor_ld ? count_floor_i : count_ceiling_i))
                        active <= buffer; // RQ8
                end
            end

            // flag sets on the tick after the match; set beats any clear
            always @(posedge clk_i) begin
                if (rst_i) begin
                    match_seen <= 1'b0;
                    flag       <= 1'b0;
                end else begin
                    if (timer_tick_i)
                        match_seen <= hit;
                    flag <= (flag & ~flag_clr) | (timer_tick_i & match_seen); // RQ2 RQ3 RQ4
                end
            end

            // waveform generator; a force behaves as a match without the flag
            always @* begin
                next_wave = wave; // RQ16 RQ21
                if (!pwm_mode) begin
                    if (hit || force_s) begin // RQ12
                        case (eff_act)
                            `T16OC_ACT_TOGGLE: next_wave = ~wave; // RQ25
                            `T16OC_ACT_CLEAR:  next_wave = 1'b0;  // RQ25
                            `T16OC_ACT_SET:    next_wave = 1'b1;  // RQ25
                            default:           next_wave = wave;
                        endcase
                    end
                end else if (fast) begin
                    if (hit) begin
                        case (action)
                            `T16OC_ACT_TOGGLE: next_wave = ~wave;
                            `T16OC_ACT_CLEAR:  next_wave = 1'b0; // RQ24
                            `T16OC_ACT_SET:    next_wave = 1'b1; // RQ24
                            default:           next_wave = wave;
                        endcase
                    end else if (timer_tick_i && count_floor_i) begin
                        case (action)
                            `T16OC_ACT_CLEAR:  next_wave = 1'b1; // RQ24 RQ5
                            `T16OC_ACT_SET:    next_wave = 1'b0; // RQ24 RQ5
                            default:           next_wave = wave;
                        endcase
                    end
                end else if (hit) begin
                    // dual slope: direction decides set or clear
                    case (action)
                        `T16OC_ACT_TOGGLE: next_wave = ~wave;
                        `T16OC_ACT_CLEAR:  next_wave = count_down_i;  // RQ5
                        `T16OC_ACT_SET:    next_wave = ~count_down_i; // RQ5
                        default:           next_wave = wave;
                    endcase
                end
            end

            // output register survives mode changes, cleared by reset and otherwise loaded from next_wave every cycle
            always @(posedge clk_i) begin
                if (rst_i)
                    wave <= 1'b0; // RQ18
                else
                    wave <= next_wave;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs toward pins, interrupt controller and counter

    // action bits feed only the pin path; nothing reaches input capture
    always @(posedge clk_i) begin
        if (rst_i) begin
            compare_irq_o     <= 2'h0;
            waveform_pin_o    <= 2'h0;
            waveform_oe_o     <= 2'h0;
            ceiling_value_o   <= `T16OC_RST_VALUE;
            waveform_select_o <= `T16OC_RST_MODE;
        end else begin
            compare_irq_o     <= flag_rd & {g_chan[1].irq_en, g_chan[0].irq_en}; // RQ3
            waveform_pin_o    <= pin_next; // RQ19 RQ20
            waveform_oe_o     <= pin_direction_bit_i; // RQ19
            ceiling_value_o   <= active_val[0]; // RQ6 RQ23
            waveform_select_o <= waveform_select; // RQ22
        end
    end

endmodule // t16oc

// ===== t16oc_checker.sv
`include "t16oc_regs.vh"
module t16oc_checker (
    input logic        clk_i,
    input logic        rst_i,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [3:0]  wb_adr_i,
    input logic [7:0]  wb_dat_i,
    input logic [7:0]  wb_dat_o,
    input logic        wb_ack_o,
    input logic        timer_tick_i,
    input logic [1:0]  irq_ack_i,
    input logic [1:0]  pin_direction_bit_i,
    input logic [1:0]  compare_irq_o,
    input logic [1:0]  waveform_pin_o,
    input logic [1:0]  waveform_oe_o,
    input logic [15:0] ceiling_value_o,
    input logic [3:0]  waveform_select_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request not yet answered, and a read being answered
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_ack = wb_ack_o && !wb_we_i;

    property p_ack;
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");
    property p_rst;
        $fell(rst_i) |-> waveform_pin_o == 2'b00 && compare_irq_o == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("output not cleared by reset");
    property p_oe;
        !$past(rst_i) |-> waveform_oe_o == $past(pin_direction_bit_i);
    endproperty
    a_oe: assert property (p_oe) else $error("enable not from direction");
    property p_svc;
        irq_ack_i[0] && !timer_tick_i |-> ##2 !compare_irq_o[0];
    endproperty
    a_svc: assert property (p_svc) else $error("service left irq up");
    property p_rise;
        $rose(compare_irq_o[0]) |-> $past(timer_tick_i, 2) || $past(wb_ack_o, 2);
    endproperty
    a_rise: assert property (p_rise) else $error("irq without tick");
    property p_mode;
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == `T16OC_ADR_MODE
            |=> ##1 waveform_select_o == $past(wb_dat_i[3:0], 2);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not taken");
    property p_frc;
        rd_ack && (wb_adr_i == `T16OC_ADR_CTRL_A || wb_adr_i == `T16OC_ADR_CTRL_B)
            |-> !wb_dat_o[`T16OC_FORCE_BIT];
    endproperty
    a_frc: assert property (p_frc) else $error("force bit read as one");
    // the active value may only move after a bus write or a timer tick
    property p_val;
        $changed(ceiling_value_o) |-> $past(timer_tick_i) || $past(timer_tick_i, 2)
            || $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    a_val: assert property (p_val) else $error("value moved alone");
endmodule // t16oc_checker

bind t16oc t16oc_checker u_t16oc_checker (.*);

// ===== t16oc_timer_model.sv
`include "t16oc_regs.vh"
module t16oc_timer_model (
    input  logic        clk_i,
    input  logic        rst_i,
    input  logic        run_i,
    input  logic        load_i,
    input  logic [15:0] load_val_i,
    input  logic [3:0]  mode_i,
    input  logic [15:0] top_i,
    output logic [15:0] count_o,
    output logic        tick_o,
    output logic        write_o,
    output logic        ceiling_o,
    output logic        floor_o,
    output logic        down_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic half;
    // only fast pwm and ctc with the top from channel A stop there; the rest, the other channel A modes included, run to full range
    assign ceiling_o = count_o == ((mode_i == `T16OC_WS_FAST_A || mode_i == `T16OC_WS_CTC_A)
                                   ? top_i : 16'hffff);
    assign floor_o = count_o == 16'h0000;
    assign down_o = 1'b0;
    // half-rate timer clock; a cpu write beats counting and is flagged with the new value
    always @(posedge clk_i) begin
        if (rst_i) begin
            {count_o, tick_o, write_o, half} <= '0;
        end else begin
            half <= run_i & ~half;
            tick_o <= run_i & ~half;
            write_o <= load_i;
            if (load_i)
                count_o <= load_val_i;
            else if (tick_o)
                count_o <= ceiling_o ? 16'h0000 : count_o + 16'h0001;
        end
    end
endmodule // t16oc_timer_model

// ===== t16oc_bench.sv
`include "t16oc_regs.vh"
module t16oc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [0:0]  wb_sel_i = 1'b1;
    logic [7:0]  wb_dat_i = 8'h00;
    logic [1:0]  irq_ack_i = 2'h0;
    logic [1:0]  port_data_i = 2'h0;
    logic [1:0]  pin_direction_bit_i = 2'h0;
    logic        run = 1'b0;
    logic        load = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic [7:0]  wb_dat_o, rdata;
    logic        wb_ack_o, timer_tick_i, timer_count_write_i;
    logic        count_ceiling_i, count_floor_i, count_down_i;
    logic [15:0] timer_count_i, ceiling_value_o;
    logic [1:0]  compare_irq_o, waveform_pin_o, waveform_oe_o;
    logic [3:0]  waveform_select_o;
    logic [1:0]  acts [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
    logic        wave [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int          mismatches = 0;
    int          total_checks = 0;
    int          n;

    always #12.5 clk_i = ~clk_i;
    t16oc u_t16oc (.*);
    t16oc_timer_model u_t16oc_timer_model (.clk_i, .rst_i, .run_i(run), .load_i(load),
        .load_val_i(load_val), .mode_i(waveform_select_o), .top_i(ceiling_value_o),
        .count_o(timer_count_i), .tick_o(timer_tick_i), .write_o(timer_count_write_i),
        .ceiling_o(count_ceiling_i), .floor_o(count_floor_i), .down_o(count_down_i));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled high
    task bus(input logic we, input logic [3:0] adr, input logic [7:0] dat);
        int k;
        k = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            results;
        end
        rdata = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task rd(input logic [3:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00);
        check(rdata, exp);
    endtask
    // a hang ends the run as a failure
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        results;
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1, `T16OC_ADR_VAL_A_HI, 8'h01);
        bus(1, `T16OC_ADR_VAL_A_LO, 8'h23);
        rd(`T16OC_ADR_VAL_A_HI, 8'h01);
        rd(`T16OC_ADR_VAL_A_LO, 8'h23);
        check(ceiling_value_o, 16'h0123);
        rd(4'h9, 8'h00);
        // force walks each output through set, toggle, toggle, clear
        pin_direction_bit_i <= 2'b11;
        for (int ch = 0; ch < 2; ch++)
            for (int k = 0; k < 4; k++) begin
                bus(1, 4'(`T16OC_ADR_CTRL_A + ch), {6'h02, acts[k]});
                rd(4'(`T16OC_ADR_CTRL_A + ch), {6'h00, acts[k]});
                check(waveform_pin_o[ch], wave[k]);
            end
        rd(`T16OC_ADR_FLAGS, 8'h00);
        check(waveform_oe_o, 2'b11);
        // action zero hands the pin back to the port; a mode change keeps B set
        port_data_i <= 2'b01;
        bus(1, `T16OC_ADR_CTRL_A, 8'h00);
        bus(1, `T16OC_ADR_CTRL_B, 8'h0b);
        bus(1, `T16OC_ADR_MODE, 8'h05);
        rd(`T16OC_ADR_MODE, 8'h05);
        check(waveform_pin_o, 2'b11);
        bus(1, `T16OC_ADR_MODE, 8'h00);
        // A toggles with its interrupt; B matches at zero
        bus(1, `T16OC_ADR_CTRL_A, 8'h05);
        run <= 1'b1;
        for (n = 0; compare_irq_o[0] !== 1'b1 && n < 2000; n++) @(posedge clk_i);
        if (n == 2000) mismatches++;
        run <= 1'b0;
        check(waveform_pin_o[0], 1'b1);
        rd(`T16OC_ADR_FLAGS, 8'h03);
        bus(1, `T16OC_ADR_FLAGS, 8'h00);
        rd(`T16OC_ADR_FLAGS, 8'h03);
        bus(1, `T16OC_ADR_FLAGS, 8'h02);
        rd(`T16OC_ADR_FLAGS, 8'h01);
        irq_ack_i <= 2'b01;
        @(posedge clk_i) irq_ack_i <= 2'b00;
        rd(`T16OC_ADR_FLAGS, 8'h00);
        check(compare_irq_o, 2'b00);
        // counter written to the match value while stopped; the next tick must not match
        {load, load_val} <= {1'b1, 16'h0123};
        @(posedge clk_i) load <= 1'b0;
        repeat (10) @(posedge clk_i);
        run <= 1'b1;
        repeat (20) @(posedge clk_i);
        run <= 1'b0;
        rd(`T16OC_ADR_FLAGS, 8'h00);
        check(waveform_pin_o[0], 1'b1);
        // top from A: the new value waits in the buffer until the old ceiling
        {load, load_val} <= {1'b1, 16'h0100};
        @(posedge clk_i) load <= 1'b0;
        bus(1, `T16OC_ADR_MODE, 8'h0f);
        bus(1, `T16OC_ADR_VAL_A_HI, 8'h01);
        bus(1, `T16OC_ADR_VAL_A_LO, 8'h08);
        bus(1, `T16OC_ADR_VAL_B_HI, 8'h00);
        bus(1, `T16OC_ADR_VAL_B_LO, 8'h04);
        rd(`T16OC_ADR_VAL_A_LO, 8'h08);
        check(ceiling_value_o, 16'h0123);
        run <= 1'b1;
        for (n = 0; ceiling_value_o !== 16'h0108 && n < 400; n++) @(posedge clk_i);
        if (n == 400) mismatches++;
        check(timer_count_i < 16'h0008, 1'b1);
        // inverting fast pwm on B: cleared at the floor, set again at its match of 4
        for (n = 0; timer_count_i !== 16'h0002 && n < 40; n++) @(posedge clk_i);
        if (n == 40) mismatches++;
        check(waveform_pin_o[1], 1'b0);
        for (n = 0; timer_count_i !== 16'h0006 && n < 40; n++) @(posedge clk_i);
        if (n == 40) mismatches++;
        check(waveform_pin_o[1], 1'b1);
        run <= 1'b0;
        results;
    end
endmodule // t16oc_bench
